// ### dv/lsrb_ctrl_tb_top.sv
// Self-checking bench for the result buffer controller
`timescale 1ns/100ps
`default_nettype none
module lsrb_ctrl_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic req = 1'b0, fin = 1'b0, smp = 1'b0, measStart = 1'b0, scanDone, scanActive;
  logic [3:0] chan = 4'h0, activeChan = 4'h0;
  logic [15:0] cnt = 16'h0000, vec = 16'h0000;
  logic [2:0] decoderEvents = 3'h0;
  logic [18:0] eventOut;
  logic dmaLevelReq, dmaSingleReq, auxOscEn, dacClk, analogPowerOn;
  logic biasHighAcc, biasCtrlEn, ramPowerOn, owMode = 1'b0;
  lsrb_pkg::lsrb_meas_t meas;
  lsrb_pkg::lsrb_dac_t dacOut;
  lsrb_pkg::lsrb_comp_t compOut;
  // Reference model state
  logic [31:0] q[$];
  logic [31:0] ring[16]; // Ring image, an empty pop shows the slot under the read pointer
  logic [15:0] thr[16];
  logic [11:0] cmpThr[16], d0;
  logic dir[16], useCnt[16];
  int wp = 0, rp = 0, n_fail = 0, checked = 0, n, div, seed, md;
  always #10 clk = ~clk;
  lsrb_seq_model seq (.clk(clk), .req(req), .fin(fin), .chan(chan), .cnt(cnt), .smp(smp),
    .meas(meas), .scanDone(scanDone), .scanActive(scanActive));
  lsrb_ctrl uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .meas(meas), .scanDone(scanDone), .measStart(measStart), .scanActive(scanActive),
    .activeChan(activeChan), .decoderEvents(decoderEvents), .eventOut(eventOut),
    .dmaLevelReq(dmaLevelReq), .dmaSingleReq(dmaSingleReq), .dacOut(dacOut),
    .auxOscEn(auxOscEn), .dacClk(dacClk), .compOut(compOut), .analogPowerOn(analogPowerOn),
    .biasHighAcc(biasHighAcc), .biasCtrlEn(biasCtrlEn), .ramPowerOn(ramPowerOn));
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50) begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rdat, e);
  endtask
  // Model push into the ring
  task automatic mpush(input logic [31:0] w);
    if (q.size() == 16 && owMode) begin
      void'(q.pop_front());
      rp = (rp + 1) % 16;
    end
    if (q.size() < 16) begin
      q.push_back(w);
      ring[wp] = w;
      wp = (wp + 1) % 16;
    end
  endtask
  // One measurement through the sequencer model
  task automatic push(input logic [3:0] ch, input logic [15:0] c, input logic s);
    vec[ch] = useCnt[ch] ? (dir[ch] ? c >= thr[ch] : c < thr[ch]) : s;
    mpush(useCnt[ch] ? {16'h0000, c} : {31'h0000_0000, s});
    req <= 1'b1;
    chan <= ch;
    cnt <= c;
    smp <= s;
    @(posedge clk);
    req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [31:0] ptrExp();
    return 32'(q.size() * 256 + wp * 16 + rp);
  endfunction
  // Pop everything, oldest first
  task automatic drain;
    while (q.size() > 0) begin
      rd(lsrb_pkg::OFF_POPDATA, q[0], "pop");
      void'(q.pop_front());
      rp = (rp + 1) % 16;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = $urandom(8);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(lsrb_pkg::OFF_POINTER, 32'h0000_0000, "ptrRst");
    rd(lsrb_pkg::OFF_STATUS, 32'h0000_0000, "statRst");
    chk("ramOn", ramPowerOn, 1);
    apb(1'b0, 12'hFFC, 32'h0000_0000);
    chk("slvErr", pslverr, 1);
    // Random channel setup, last four in comparator mode
    for (int i = 0; i < 16; i++) begin
      thr[i] = 16'($urandom);
      dir[i] = 1'($urandom);
      useCnt[i] = i < 12;
      cmpThr[i] = 12'($urandom);
      wr(lsrb_pkg::OFF_CHCFG + 12'(4 * i), {cmpThr[i], 2'b01, useCnt[i], dir[i], thr[i]});
    end
    // Seventeen pushes around each threshold; the last overflows
    for (int i = 0; i < 17; i++)
      push(4'(i), thr[i % 16] + 16'($urandom % 3) - 16'h0001, 1'($urandom));
    rd(lsrb_pkg::OFF_SCANVEC, {16'h0000, vec}, "scanVec");
    chk("evVec", eventOut[18:3], vec);
    rd(lsrb_pkg::OFF_POINTER, ptrExp(), "ptrFull");
    rd(lsrb_pkg::OFF_STATUS, 32'h0000_0007, "statFull");
    rd(lsrb_pkg::OFF_IFLAG, 32'h0000_0007, "ifFull");
    chk("dmaLvl", dmaLevelReq, 1);
    chk("dmaOne", dmaSingleReq, 1);
    rd(lsrb_pkg::OFF_SLOT + 12'h00C, q[3 - rp], "slot3");
    rd(lsrb_pkg::OFF_POINTER, ptrExp(), "ptrSlot");
    drain();
    rd(lsrb_pkg::OFF_POPDATA, ring[rp], "popEmpty");
    rd(lsrb_pkg::OFF_POINTER, ptrExp(), "ptrEmpty");
    chk("dmaIdle", dmaSingleReq, 0);
    wr(lsrb_pkg::OFF_IFLAG, 32'h0000_0007);
    rd(lsrb_pkg::OFF_IFLAG, 32'h0000_0000, "ifClr");
    // Overwrite mode: keep the newest sixteen
    wr(lsrb_pkg::OFF_CTRL, 32'h0000_0001);
    owMode = 1'b1;
    for (int i = 0; i < 18; i++)
      push(4'($urandom), 16'($urandom), 1'($urandom));
    rd(lsrb_pkg::OFF_POINTER, ptrExp(), "ptrOw");
    rd(lsrb_pkg::OFF_IFLAG, 32'h0000_0007, "ifOw");
    wr(lsrb_pkg::OFF_CTRL, 32'h0000_0003);
    chk("lvlFull", dmaLevelReq, 1);
    rd(lsrb_pkg::OFF_POPDATA, q.pop_front(), "popOw");
    rp = (rp + 1) % 16;
    repeat (2) @(posedge clk);
    chk("lvlDrop", dmaLevelReq, 0);
    // Vector word at scan end
    wr(lsrb_pkg::OFF_CTRL, 32'h0000_0005);
    fin <= 1'b1;
    @(posedge clk);
    fin <= 1'b0;
    repeat (4) @(posedge clk);
    mpush({16'h0000, vec});
    drain();
    // DAC refresh timing and comparator drive
    div = 1 + $urandom % 7;
    d0 = 12'($urandom);
    md = $urandom % 16;
    wr(lsrb_pkg::OFF_DACDATA0, {20'h0_0000, d0});
    wr(lsrb_pkg::OFF_PERIPHERAL_CONTROL, 32'(div * 64) + 32'h0000_3000 + 32'(md));
    activeChan <= 4'hA;
    measStart <= 1'b1;
    @(posedge clk);
    measStart <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n == 1) begin
        chk("auxOn", auxOscEn, 1);
      end
      if (n == div + 1) begin
        chk("dacClk", dacClk, 1);
      end
    end while (dacOut.update !== 1'b1 && n < 40);
    // Refresh spans the set number of divided ticks, each divider plus one cycles
    chk("dacLat", n, int'(lsrb_pkg::DAC_REFRESH_TICKS) * (div + 1));
    chk("auxOff", auxOscEn, 0);
    chk("dacMode", {dacOut.mode1, dacOut.mode0}, 32'(md));
    chk("dacData", dacOut.data0, d0);
    chk("cmp1", {compOut.muxDrv1, compOut.mux1, compOut.scaleDrv1, compOut.scale1},
      {1'b1, 3'h2, 1'b1, cmpThr[10][5:0]});
    chk("warm", analogPowerOn, 1);
    // Bias modes and decoder events
    wr(lsrb_pkg::OFF_BIASCTRL, 32'h0000_0001);
    decoderEvents <= 3'($urandom);
    repeat (2) @(posedge clk);
    chk("biasAcc", biasHighAcc, 1);
    chk("evDec", eventOut[2:0], decoderEvents);
    wr(lsrb_pkg::OFF_BIASCTRL, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk("biasOff", biasCtrlEn, 0);
    // Cycled bias: high accuracy only while a scan runs
    wr(lsrb_pkg::OFF_BIASCTRL, 32'h0000_0000);
    push(4'h0, 16'h0000, 1'b0);
    chk("biasCyc", biasHighAcc, 1);
    wr(lsrb_pkg::OFF_PWRDN, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("ramOff", ramPowerOn, 0);
    print_verdict();
  end
endmodule
`default_nettype wire

// ### dv/lsrb_seq_model.sv
// Sequencer model feeding measurements and scan completion
`timescale 1ns/100ps
`default_nettype none
module lsrb_seq_model (
  input wire logic clk,
  input wire logic req,
  input wire logic fin,
  input wire logic [3:0] chan,
  input wire logic [15:0] cnt,
  input wire logic smp,
  output lsrb_pkg::lsrb_meas_t meas,
  output logic scanDone,
  output logic scanActive
);
  initial begin
    meas = '0;
    scanDone = 1'b0;
    scanActive = 1'b0;
  end
  // One pulse per request; idle fields flip so stale values never pass
  always @(posedge clk) begin
    meas.valid <= req;
    meas.chan <= req ? chan : ~meas.chan;
    meas.count <= req ? cnt : ~meas.count;
    meas.compSample <= req ? smp : ~meas.compSample;
    scanDone <= fin;
    scanActive <= req | (scanActive & ~fin);
  end
endmodule
`default_nettype wire

// ### hw/lsrb_ctrl.sv
// Sensor result buffer controller with APB registers, DAC and comparator control
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module lsrb_ctrl #(
  parameter int DEPTH = 16,
  parameter int CHANNELS = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire lsrb_pkg::lsrb_meas_t meas,
  input wire logic scanDone,
  input wire logic measStart,
  input wire logic scanActive,
  input wire logic [3:0] activeChan,
  input wire logic [2:0] decoderEvents,
  output logic [18:0] eventOut,
  output logic dmaLevelReq,
  output logic dmaSingleReq,
  output lsrb_pkg::lsrb_dac_t dacOut,
  output logic auxOscEn,
  output logic dacClk,
  output lsrb_pkg::lsrb_comp_t compOut,
  output logic analogPowerOn,
  output logic biasHighAcc,
  output logic biasCtrlEn,
  output logic ramPowerOn
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [3:0] wrPtr;
    logic [3:0] rdPtr;
    logic [4:0] count;
    logic [2:0] ctrl;
    logic [13:0] peripheral_control;
    logic [1:0] bias;
    logic [11:0] dacData0;
    logic [11:0] dacData1;
    logic [2:0] iflag;
    logic [15:0] scanVec;
    logic vecPend;
    logic ramOff;
    logic ramOn; // Registered RAM power state for the pin
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [18:0] eventOut;
    logic dmaLevel;
    logic dmaSingle;
    lsrb_pkg::lsrb_dac_state_t dacState;
    logic [1:0] dacTicks;
    logic [2:0] divCnt;
    logic auxOscEn;
    logic dacClk;
    lsrb_pkg::lsrb_dac_t dac;
    lsrb_pkg::lsrb_comp_t comp;
    logic analogOn;
    logic biasHigh;
    logic biasEn;
  } lsrb_state_t;

  lsrb_state_t q; // Registered state
  lsrb_state_t d; // Next state

  logic [31:0] bufMem [DEPTH]; // Result ring, RAM backed, not reset
  logic [31:0] chCfg [CHANNELS]; // Channel config words, RAM backed, not reset
  logic bufWe; // Ring write strobe
  logic [31:0] bufWdata; // Ring write data
  logic cfgWe; // Channel config write strobe

  // Bus phase decode
  logic setup, wrAcc, rdAcc, isSlot, isCfg; // Phase, access and region strobes
  assign setup = psel & ~penable;
  assign wrAcc = psel & penable & q.pready & pwrite;
  assign rdAcc = psel & penable & q.pready & ~pwrite;
  assign isSlot = paddr[11:6] == lsrb_pkg::OFF_SLOT[11:6];
  assign isCfg = paddr[11:6] == lsrb_pkg::OFF_CHCFG[11:6];

  // Buffer movement terms, shared with the checks below
  logic full, pop, pushReq, pushEff, rdFollow, levelHit, triggered; // Ring movement terms
  logic [31:0] cfgMeas;
  logic [31:0] cfgAct;
  assign cfgMeas = chCfg[meas.chan];
  assign cfgAct = chCfg[activeChan];
  assign full = q.count == lsrb_pkg::FULL_LEVEL;
  assign levelHit = q.ctrl[lsrb_pkg::CTRL_LVLSEL] ? full : (q.count >= lsrb_pkg::HALF_LEVEL);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic samplePush, vecPush, rdInc, tick; // Per-cycle push, pop and tick terms
    logic [1:0] cm;
    samplePush = 1'b0;
    vecPush = 1'b0;
    rdInc = 1'b0;
    tick = 1'b0;
    cm = 2'h0;
    d = q;
    bufWe = 1'b0;
    bufWdata = 32'h0000_0000;
    cfgWe = 1'b0;
    // Sensor evaluation
    if (cfgMeas[lsrb_pkg::CH_USECNT]) begin
      triggered = cfgMeas[lsrb_pkg::CH_CNTDIR] ? (meas.count >= cfgMeas[15:0])
                                               : (meas.count < cfgMeas[15:0]);
    end else begin
      triggered = meas.compSample;
    end
    if (meas.valid) begin
      d.scanVec[meas.chan] = triggered;
    end
    // Buffer pushes: samples first, vector waits for a cycle with no sample push
    samplePush = meas.valid & cfgMeas[lsrb_pkg::CH_STORE] & ~q.ramOff;
    vecPush = (q.vecPend | (scanDone & q.ctrl[lsrb_pkg::CTRL_STRVEC])) & ~samplePush
              & ~q.ramOff;
    d.vecPend = (q.vecPend | (scanDone & q.ctrl[lsrb_pkg::CTRL_STRVEC])) & samplePush
                & ~q.ramOff;
    pushReq = samplePush | vecPush;
    if (samplePush) begin
      bufWdata = cfgMeas[lsrb_pkg::CH_USECNT] ? {16'h0000, meas.count} : {31'h0, meas.compSample};
    end else begin
      bufWdata = {16'h0000, d.scanVec};
    end
    // Pop only when unread data exists
    pop = rdAcc & (paddr == lsrb_pkg::OFF_POPDATA) & (q.count != 5'h00) & ~q.ramOff;
    pushEff = pushReq & (~full | pop | q.ctrl[lsrb_pkg::CTRL_OW]);
    rdFollow = pushReq & full & ~pop & q.ctrl[lsrb_pkg::CTRL_OW];
    rdInc = pop | rdFollow;
    if (pushEff) begin
      bufWe = 1'b1;
      d.wrPtr = q.wrPtr + 4'h1;
    end
    if (rdInc) begin
      d.rdPtr = q.rdPtr + 4'h1;
    end
    if (pushEff & ~rdInc) begin
      d.count = q.count + 5'h01;
    end else if (rdInc & ~pushEff) begin
      d.count = q.count - 5'h01;
    end
    // Sticky flags, set beats write-one-to-clear
    if (wrAcc & (paddr == lsrb_pkg::OFF_IFLAG)) begin
      d.iflag = q.iflag & ~pwdata[2:0];
    end
    if (q.count != 5'h00) begin
      d.iflag[lsrb_pkg::IF_DATAV] = 1'b1;
    end
    if (levelHit) begin
      d.iflag[lsrb_pkg::IF_LEVEL] = 1'b1;
    end
    if (pushReq & full & ~pop) begin
      d.iflag[lsrb_pkg::IF_OVF] = 1'b1;
    end
    // DMA requests follow the live level
    d.dmaLevel = levelHit;
    d.dmaSingle = q.count != 5'h00;
    // Event routing: decoder outputs then scan vector bits
    d.eventOut = {d.scanVec, decoderEvents};
    // Register writes
    if (wrAcc) begin
      case (paddr)
        lsrb_pkg::OFF_CTRL: d.ctrl = pwdata[lsrb_pkg::CTRL_W-1:0];
        lsrb_pkg::OFF_PERIPHERAL_CONTROL: d.peripheral_control = pwdata[lsrb_pkg::PC_W-1:0];
        lsrb_pkg::OFF_BIASCTRL: d.bias = pwdata[1:0];
        lsrb_pkg::OFF_DACDATA0: d.dacData0 = pwdata[11:0];
        lsrb_pkg::OFF_DACDATA1: d.dacData1 = pwdata[11:0];
        lsrb_pkg::OFF_PWRDN: begin
          if (pwdata[0]) begin
            d.ramOff = 1'b1;
          end
        end
        default: begin
          cfgWe = isCfg & ~q.ramOff;
        end
      endcase
    end
    d.ramOn = ~d.ramOff;
    // Bus answer: data captured in setup, ready in the first access cycle
    d.pready = setup;
    if (setup) begin
      d.pslverr = 1'b0;
      d.prdata = 32'h0000_0000;
      case (paddr)
        lsrb_pkg::OFF_CTRL: d.prdata = {29'h0, q.ctrl};
        lsrb_pkg::OFF_PERIPHERAL_CONTROL: d.prdata = {18'h0, q.peripheral_control};
        lsrb_pkg::OFF_BIASCTRL: d.prdata = {30'h0, q.bias};
        lsrb_pkg::OFF_SCANVEC: d.prdata = {16'h0000, q.scanVec};
        lsrb_pkg::OFF_STATUS: d.prdata = {27'h0, q.dacState == lsrb_pkg::DAC_RUN, q.ramOff,
                                          full, q.count >= lsrb_pkg::HALF_LEVEL,
                                          q.count != 5'h00};
        lsrb_pkg::OFF_POINTER: d.prdata = {19'h0, q.count, q.wrPtr, q.rdPtr};
        lsrb_pkg::OFF_POPDATA: d.prdata = q.ramOff ? 32'h0000_0000 : bufMem[q.rdPtr];
        lsrb_pkg::OFF_IFLAG: d.prdata = {29'h0, q.iflag};
        lsrb_pkg::OFF_PWRDN: d.prdata = {31'h0, q.ramOff};
        lsrb_pkg::OFF_DACDATA0: d.prdata = {20'h0, q.dacData0};
        lsrb_pkg::OFF_DACDATA1: d.prdata = {20'h0, q.dacData1};
        default: begin
          if (isSlot) begin
            d.prdata = q.ramOff ? 32'h0000_0000 : bufMem[paddr[5:2]];
          end else if (isCfg) begin
            d.prdata = q.ramOff ? 32'h0000_0000 : chCfg[paddr[5:2]];
          end else begin
            d.pslverr = 1'b1;
          end
        end
      endcase
    end
    // DAC refresh: oscillator runs only for the refresh
    tick = q.divCnt == q.peripheral_control[lsrb_pkg::PC_DIV+:3];
    d.dac.update = 1'b0;
    case (q.dacState)
      lsrb_pkg::DAC_IDLE: begin
        d.auxOscEn = 1'b0;
        d.dacClk = 1'b0;
        if (measStart) begin
          d.dacState = lsrb_pkg::DAC_RUN;
          d.auxOscEn = 1'b1;
          d.divCnt = 3'h0;
          d.dacTicks = 2'h0;
          d.dac.mode0 = q.peripheral_control[lsrb_pkg::PC_DAC0MODE+:2];
          d.dac.mode1 = q.peripheral_control[lsrb_pkg::PC_DAC1MODE+:2];
          d.dac.data0 = q.peripheral_control[lsrb_pkg::PC_DAC0SEL] ? cfgAct[31:20] : q.dacData0;
          d.dac.data1 = q.peripheral_control[lsrb_pkg::PC_DAC1SEL] ? cfgAct[31:20] : q.dacData1;
        end
      end
      lsrb_pkg::DAC_RUN: begin
        d.divCnt = tick ? 3'h0 : q.divCnt + 3'h1;
        if (tick) begin
          d.dacClk = ~q.dacClk;
          d.dacTicks = q.dacTicks + 2'h1;
          if (q.dacTicks == lsrb_pkg::DAC_REFRESH_TICKS - 2'h1) begin
            d.dac.update = 1'b1;
            d.dacState = lsrb_pkg::DAC_IDLE;
            d.auxOscEn = 1'b0;
          end
        end
      end
      default: d.dacState = lsrb_pkg::DAC_IDLE;
    endcase
    // Comparator mux and supply scale, comparator 0 serves channels 0-7
    cm = q.peripheral_control[lsrb_pkg::PC_CMP0MODE+:2];
    d.comp.muxDrv0 = (cm == lsrb_pkg::CMP_MUX) | (cm == lsrb_pkg::CMP_MUXSCALE);
    d.comp.scaleDrv0 = cm == lsrb_pkg::CMP_MUXSCALE;
    cm = q.peripheral_control[lsrb_pkg::PC_CMP1MODE+:2];
    d.comp.muxDrv1 = (cm == lsrb_pkg::CMP_MUX) | (cm == lsrb_pkg::CMP_MUXSCALE);
    d.comp.scaleDrv1 = cm == lsrb_pkg::CMP_MUXSCALE;
    if (~activeChan[3]) begin
      d.comp.mux0 = activeChan[2:0];
      d.comp.scale0 = cfgAct[lsrb_pkg::CH_CMPTHR+:6];
    end else begin
      d.comp.mux1 = activeChan[2:0];
      d.comp.scale1 = cfgAct[lsrb_pkg::CH_CMPTHR+:6];
    end
    // Analog power and bias duty cycling
    d.analogOn = q.peripheral_control[lsrb_pkg::PC_WARMUP] | scanActive
                 | (q.dacState == lsrb_pkg::DAC_RUN);
    d.biasEn = q.bias != lsrb_pkg::BIAS_UNTOUCHED;
    d.biasHigh = (q.bias == lsrb_pkg::BIAS_ACCURATE)
                 | ((q.bias == lsrb_pkg::BIAS_CYCLED) & scanActive);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, synchronous active-low reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.ctrl <= lsrb_pkg::CTRL_RST;
      q.peripheral_control <= lsrb_pkg::PERIPHERAL_CONTROL_RST;
      q.bias <= lsrb_pkg::BIAS_RST;
      q.dacState <= lsrb_pkg::DAC_IDLE;
      q.ramOn <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // RAM-backed storage: contents undefined after reset
  always_ff @(posedge clk) begin
    if (bufWe) begin
      bufMem[q.wrPtr] <= bufWdata;
    end
    if (cfgWe) begin
      chCfg[paddr[5:2]] <= pwdata;
    end
  end

  // Outputs straight from the state register
  assign pready = q.pready;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign eventOut = q.eventOut;
  assign dmaLevelReq = q.dmaLevel;
  assign dmaSingleReq = q.dmaSingle;
  assign dacOut = q.dac;
  assign auxOscEn = q.auxOscEn;
  assign dacClk = q.dacClk;
  assign compOut = q.comp;
  assign analogPowerOn = q.analogOn;
  assign biasHighAcc = q.biasHigh;
  assign biasCtrlEn = q.biasEn;
  assign ramPowerOn = q.ramOn;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_wr_advance;
    @(posedge clk) disable iff (!rst_n) pushEff |=> q.wrPtr == $past(q.wrPtr) + 4'h1;
  endproperty
  a_wr_advance: assert property (p_wr_advance) else $error("write pointer did not advance");
  property p_empty_pop;
    @(posedge clk) disable iff (!rst_n)
      (rdAcc && paddr == lsrb_pkg::OFF_POPDATA && q.count == 5'h00) |=> $stable(q.rdPtr);
  endproperty
  a_empty_pop: assert property (p_empty_pop) else $error("read pointer moved on empty");
  property p_full_drop;
    @(posedge clk) disable iff (!rst_n)
      (pushReq && full && !pop && !q.ctrl[lsrb_pkg::CTRL_OW]) |=> $stable(q.wrPtr) && full;
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("stored into full buffer");
  property p_ow_follow;
    @(posedge clk) disable iff (!rst_n)
      (pushReq && full && !pop && q.ctrl[lsrb_pkg::CTRL_OW])
      |=> q.rdPtr == $past(q.rdPtr) + 4'h1 && q.rdPtr == q.wrPtr;
  endproperty
  a_ow_follow: assert property (p_ow_follow) else $error("read pointer did not follow");
  property p_full_ptrs;
    @(posedge clk) disable iff (!rst_n) full |-> q.wrPtr == q.rdPtr;
  endproperty
  a_full_ptrs: assert property (p_full_ptrs) else $error("full but pointers differ");
  property p_overflow;
    @(posedge clk) disable iff (!rst_n) (pushReq && full && !pop) |=> q.iflag[lsrb_pkg::IF_OVF];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag not set");
  property p_cmp_trigger;
    @(posedge clk) disable iff (!rst_n)
      (meas.valid && !cfgMeas[lsrb_pkg::CH_USECNT])
      |=> q.scanVec[$past(meas.chan)] == $past(meas.compSample);
  endproperty
  a_cmp_trigger: assert property (p_cmp_trigger) else $error("scan vector bit wrong");
  property p_slot_read;
    @(posedge clk) disable iff (!rst_n)
      (rdAcc && isSlot && !pushReq) |=> $stable(q.rdPtr) && $stable(q.count);
  endproperty
  a_slot_read: assert property (p_slot_read) else $error("slot read moved buffer");
  property p_dac_refresh;
    @(posedge clk) disable iff (!rst_n)
      (measStart && q.dacState == lsrb_pkg::DAC_IDLE) |-> ##[1:40] q.dac.update;
  endproperty
  a_dac_refresh: assert property (p_dac_refresh) else $error("DAC refresh missing");
  property p_ram_sticky;
    @(posedge clk) disable iff (!rst_n) q.ramOff |=> q.ramOff;
  endproperty
  a_ram_sticky: assert property (p_ram_sticky) else $error("RAM came back on");
  property p_dma_single;
    @(posedge clk) disable iff (!rst_n) (q.count != 5'h00) |=> dmaSingleReq;
  endproperty
  a_dma_single: assert property (p_dma_single) else $error("single DMA request missing");
  c_fill: cover property (@(posedge clk) disable iff (!rst_n) full);
  c_overwrite: cover property (@(posedge clk) disable iff (!rst_n) rdFollow);
  c_pop: cover property (@(posedge clk) disable iff (!rst_n) pop);
  c_dac: cover property (@(posedge clk) disable iff (!rst_n) q.dac.update);

endmodule
`default_nettype wire

// ### hw/lsrb_pkg.sv
// Shared constants and types for the sensor result buffer controller
`default_nettype none
package lsrb_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_PERIPHERAL_CONTROL = 12'h008;
  localparam logic [11:0] OFF_BIASCTRL = 12'h010;
  localparam logic [11:0] OFF_SCANVEC = 12'h01C;
  localparam logic [11:0] OFF_STATUS = 12'h020;
  localparam logic [11:0] OFF_POINTER = 12'h024;
  localparam logic [11:0] OFF_POPDATA = 12'h028;
  localparam logic [11:0] OFF_IFLAG = 12'h040;
  localparam logic [11:0] OFF_PWRDN = 12'h044;
  localparam logic [11:0] OFF_DACDATA0 = 12'h048;
  localparam logic [11:0] OFF_DACDATA1 = 12'h04C;
  localparam logic [11:0] OFF_CHCFG = 12'h100;
  localparam logic [11:0] OFF_SLOT = 12'h200;
  // Control register fields
  localparam int CTRL_OW = 0;
  localparam int CTRL_LVLSEL = 1;
  localparam int CTRL_STRVEC = 2;
  localparam int CTRL_W = 3;
  // Peripheral control fields (low bit of each)
  localparam int PC_DAC0MODE = 0;
  localparam int PC_DAC1MODE = 2;
  localparam int PC_DAC0SEL = 4;
  localparam int PC_DAC1SEL = 5;
  localparam int PC_DIV = 6;
  localparam int PC_CMP0MODE = 9;
  localparam int PC_CMP1MODE = 11;
  localparam int PC_WARMUP = 13;
  localparam int PC_W = 14;
  // Channel configuration word fields
  localparam int CH_CNTDIR = 16;
  localparam int CH_USECNT = 17;
  localparam int CH_STORE = 18;
  localparam int CH_CMPTHR = 20;
  // Interrupt flag bits
  localparam int IF_DATAV = 0;
  localparam int IF_LEVEL = 1;
  localparam int IF_OVF = 2;
  // Buffer levels and reset values
  localparam logic [4:0] HALF_LEVEL = 5'h08;
  localparam logic [4:0] FULL_LEVEL = 5'h10;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [13:0] PERIPHERAL_CONTROL_RST = 14'h0000;
  localparam logic [1:0] BIAS_RST = 2'h0;
  // Bias modes: cycled, accurate, untouched
  localparam logic [1:0] BIAS_CYCLED = 2'h0;
  localparam logic [1:0] BIAS_ACCURATE = 2'h1;
  localparam logic [1:0] BIAS_UNTOUCHED = 2'h2;
  // Comparator control modes
  localparam logic [1:0] CMP_MUX = 2'h1;
  localparam logic [1:0] CMP_MUXSCALE = 2'h2;
  // Divided DAC clock ticks per refresh
  localparam logic [1:0] DAC_REFRESH_TICKS = 2'h2;
  typedef enum logic [0:0] {DAC_IDLE, DAC_RUN} lsrb_dac_state_t;
  // One measurement from the sequencer
  typedef struct packed {
    logic valid;
    logic [3:0] chan;
    logic [15:0] count;
    logic compSample;
  } lsrb_meas_t;
  // DAC drive bundle
  typedef struct packed {
    logic update;
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic [11:0] data0;
    logic [11:0] data1;
  } lsrb_dac_t;
  // Comparator control bundle, one half per comparator
  typedef struct packed {
    logic muxDrv0;
    logic [2:0] mux0;
    logic scaleDrv0;
    logic [5:0] scale0;
    logic muxDrv1;
    logic [2:0] mux1;
    logic scaleDrv1;
    logic [5:0] scale1;
  } lsrb_comp_t;
endpackage
`default_nettype wire
